// >>> bench/rcl_reset_cause_asserts.sv
// checker for the reset cause logic, bound to its top module
// assumes one clock and the asynchronous active-low power-on reset
`timescale 1ns/1ns
module rcl_reset_cause_asserts
   import rcl_pkg::*;
(
   input wire logic CLOCK_I, RST_N_I, SFR_WR_I, SFR_RD_I, SFR_SEL_O,
   input wire logic [7:0] SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O,
   input wire logic PIN_RST_N_I, CMP_RESET_EN_O, MCD_EN_O,
   input wire logic VDD_RESET_EN_O, SYS_RESET_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   logic hit;
   logic set_ok;
   assign hit = SFR_ADDR_I == RCL_ADDR_RESET_CAUSE;
   // a force in the same write clears every enable, so leave it out
   assign set_ok = SFR_WR_I && hit && !SYS_RESET_O && !SFR_WDATA_I[RCL_BIT_SW];
   a_sel_decode: assert property (SFR_SEL_O == hit) else $error("bad select");
   a_bit7_zero: assert property (SFR_RD_I && hit |=> !SFR_RDATA_O[7]) else $error("bit 7");
   a_rdata_hold: assert property (!(SFR_RD_I && hit) |=> $stable(SFR_RDATA_O))
      else $error("read data moved");
   a_sw_force: assert property (SFR_WR_I && hit && SFR_WDATA_I[RCL_BIT_SW]
      && !SYS_RESET_O |=> SYS_RESET_O) else $error("no force");
   a_hold_len: assert property ($rose(SYS_RESET_O) |-> SYS_RESET_O[*8] ##1 !SYS_RESET_O)
      else $error("hold length");
   a_en_clear: assert property ($rose(SYS_RESET_O) |-> !(CMP_RESET_EN_O || MCD_EN_O
      || VDD_RESET_EN_O)) else $error("enables kept");
   a_cmp_en: assert property (set_ok && SFR_WDATA_I[5] |=> CMP_RESET_EN_O)
      else $error("cmp");
   a_mcd_en: assert property (set_ok && SFR_WDATA_I[2] |=> MCD_EN_O) else $error("mcd");
   a_vdd_en: assert property (set_ok && SFR_WDATA_I[1] |=> VDD_RESET_EN_O)
      else $error("vdd");
   a_pin_reset: assert property ($fell(PIN_RST_N_I) && !SYS_RESET_O
      |-> ##[1:6] SYS_RESET_O) else $error("pin ignored");
endmodule
bind rcl_reset_cause rcl_reset_cause_asserts u_chk (
   .CLOCK_I(CLOCK_I),
   .RST_N_I(RST_N_I),
   .SFR_WR_I(SFR_WR_I),
   .SFR_RD_I(SFR_RD_I),
   .SFR_SEL_O(SFR_SEL_O),
   .SFR_ADDR_I(SFR_ADDR_I),
   .SFR_WDATA_I(SFR_WDATA_I),
   .SFR_RDATA_O(SFR_RDATA_O),
   .PIN_RST_N_I(PIN_RST_N_I),
   .CMP_RESET_EN_O(CMP_RESET_EN_O),
   .MCD_EN_O(MCD_EN_O),
   .VDD_RESET_EN_O(VDD_RESET_EN_O),
   .SYS_RESET_O(SYS_RESET_O)
);

// >>> bench/rcl_reset_cause_test.sv
// self-checking bench for the reset cause logic with its source model
// assumes one-cycle bus strobes taken at the rising edge
`timescale 1ns/1ns
module rcl_reset_cause_test;
   import rcl_pkg::*;
   logic CLOCK_I = 0, RST_N_I = 0, SFR_WR_I = 0, SFR_RD_I = 0;
   logic [7:0] SFR_ADDR_I = 8'h00, SFR_WDATA_I = 8'h00, SFR_RDATA_O, d;
   logic SFR_SEL_O, MEM_ERR_I, CMP_OUT_I, WDT_OVF_I, MCD_TIMEOUT_I, VDD_LOW_I, PIN_RST_N_I;
   logic CMP_RESET_EN_O, MCD_EN_O, VDD_RESET_EN_O, SYS_RESET_O;
   logic [5:0] fire = 6'h00;
   logic [2:0] en_m;
   int n_errors = 0, tests_run = 0, cyc = 0;
   int bitv[6] = '{RCL_BIT_MEM, RCL_BIT_CMP, RCL_BIT_WDT, RCL_BIT_MCD, RCL_BIT_POR, RCL_BIT_PIN};
   rcl_reset_cause dut (.*);
   rcl_src_model u_src (.fire_i(fire), .mem_o(MEM_ERR_I), .cmp_n_o(CMP_OUT_I),
      .wdt_o(WDT_OVF_I), .mcd_o(MCD_TIMEOUT_I), .vdd_o(VDD_LOW_I), .pin_n_o(PIN_RST_N_I));
   initial forever #25 CLOCK_I = !CLOCK_I;
   always @(posedge CLOCK_I) begin
      cyc++;
      if (cyc == 1000) begin
         n_errors++;
         $display("BAD %0t timeout", $time);
         print_verdict;
      end
   end
   function logic [7:0] exp_cause(input int i);
      return 8'h01 << bitv[i];
   endfunction
   task chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
      @(negedge CLOCK_I);
      SFR_ADDR_I = a;
      SFR_WDATA_I = v;
      SFR_WR_I = w;
      SFR_RD_I = !w;
      @(negedge CLOCK_I);
      SFR_WR_I = 0;
      SFR_RD_I = 0;
   endtask
   task rd(input logic [7:0] e);
      acc(0, RCL_ADDR_RESET_CAUSE, 8'h00);
      chk(SFR_RDATA_O, e);
   endtask
   // counts reset cycles over a window wide enough for sync latency plus hold
   task pulse(input logic [7:0] e);
      logic [7:0] n;
      n = 8'h00;
      repeat (16) begin
         if (SYS_RESET_O === 1'b1) begin
            n++;
            fire = 6'h00;
         end
         @(negedge CLOCK_I);
      end
      chk(n, e);
   endtask
   task print_verdict;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(39));
      repeat (4) @(negedge CLOCK_I);
      RST_N_I = 1;
      rd(RCL_CAUSE_POR);
      fire = 6'h02;
      pulse(8'h00);
      fire = 6'h00;
      d = 8'($urandom);
      if (d == RCL_ADDR_RESET_CAUSE) d = 8'hEE;
      acc(1, d, 8'h10);
      pulse(8'h00);
      en_m = 3'h0;
      // plain writes only: flags read back differ from what a write means
      repeat (6) begin
         d = 8'($urandom) & 8'hEF;
         acc(1, RCL_ADDR_RESET_CAUSE, d);
         en_m |= {d[5], d[2], d[1]};
         chk({5'h00, CMP_RESET_EN_O, MCD_EN_O, VDD_RESET_EN_O}, {5'h00, en_m});
      end
      rd(RCL_CAUSE_POR);
      for (int i = 0; i < 6; i++) begin
         acc(1, RCL_ADDR_RESET_CAUSE, 8'h26);
         fire[i] = 1'b1;
         pulse(8'h08);
         rd(exp_cause(i));
      end
      acc(1, RCL_ADDR_RESET_CAUSE, 8'h10);
      pulse(8'h08);
      rd(8'h10);
      print_verdict;
   end
endmodule

// >>> bench/rcl_src_model.sv
// far-side model: reset sources held as levels from a one-hot fire vector
// assumes the bench drops a source once the system reset is seen
`timescale 1ns/1ns
module rcl_src_model (
   input wire logic [5:0] fire_i,
   output logic mem_o, cmp_n_o, wdt_o, mcd_o, vdd_o, pin_n_o
);
   assign mem_o = fire_i[0];
   assign cmp_n_o = !fire_i[1];
   assign wdt_o = fire_i[2];
   assign mcd_o = fire_i[3];
   // supply stays settled unless fired, so enabling the monitor is safe
   assign vdd_o = fire_i[4];
   assign pin_n_o = !fire_i[5];
endmodule

// >>> design/rcl_pkg.sv
// constants shared by the reset cause logic: address, bit positions, encodings
// assumes an 8-bit special function register bus with one-cycle read and write strobes
package rcl_pkg;
   localparam logic [7:0] RCL_ADDR_RESET_CAUSE = 8'hEF;
   localparam int RCL_BIT_MEM = 6;
   localparam int RCL_BIT_CMP = 5;
   localparam int RCL_BIT_SW = 4;
   localparam int RCL_BIT_WDT = 3;
   localparam int RCL_BIT_MCD = 2;
   localparam int RCL_BIT_POR = 1;
   localparam int RCL_BIT_PIN = 0;
   localparam logic [7:0] RCL_CAUSE_POR = 8'h02;
   localparam logic [7:0] RCL_ZERO = 8'h00;
   localparam logic [7:0] RCL_READ_MASK = 8'h7F;
   // cycles the system reset request is held once a source fires
   localparam logic [3:0] RCL_HOLD_CYCLES = 4'h8;
   localparam logic [3:0] RCL_HOLD_ZERO = 4'h0;
   localparam logic [3:0] RCL_HOLD_STEP = 4'h1;
   // idle levels of the synchroniser chains: active-high sources rest low,
   // the active-low comparator output and reset pin rest high
   localparam logic [2:0] RCL_SYNC_LOW = 3'h0;
   localparam logic [2:0] RCL_SYNC_HIGH = 3'h7;
   typedef enum logic [2:0] {
      RCL_SRC_NONE,
      RCL_SRC_MEM,
      RCL_SRC_CMP,
      RCL_SRC_SW,
      RCL_SRC_WDT,
      RCL_SRC_MCD,
      RCL_SRC_VDD,
      RCL_SRC_PIN
   } rcl_src_e;
endpackage

// >>> design/rcl_reset_cause.sv
// reset cause logic: records which source caused the last system reset and
// enables comparator, missing clock and supply monitor reset sources.
// assumes: RST_N_I is the power-on reset; event inputs come from pins or other
// clocks and are synchronised here; SYS_RESET_O drives the rest of the chip.
`timescale 1ns/1ns
module rcl_reset_cause
   import rcl_pkg::*;
(
   // clock and power-on reset
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   // special function register bus
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic [7:0] SFR_WDATA_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   output logic [7:0] SFR_RDATA_O,
   output logic SFR_SEL_O,
   // reset sources, all asynchronous to the clock
   input wire logic MEM_ERR_I,
   input wire logic CMP_OUT_I,
   input wire logic WDT_OVF_I,
   input wire logic MCD_TIMEOUT_I,
   input wire logic VDD_LOW_I,
   input wire logic PIN_RST_N_I,
   // enables seen by the sources and the resulting reset request
   output logic CMP_RESET_EN_O,
   output logic MCD_EN_O,
   output logic VDD_RESET_EN_O,
   output logic SYS_RESET_O
);
   // synchroniser chains, stage 0 faces the pin
   logic [2:0] mem_s_r;
   logic [2:0] cmp_s_r;
   logic [2:0] wdt_s_r;
   logic [2:0] mcd_s_r;
   logic [2:0] vdd_s_r;
   logic [2:0] pin_s_r;
   // settled source levels
   logic mem_q_r;
   logic cmp_q_r;
   logic wdt_q_r;
   logic mcd_q_r;
   logic vdd_q_r;
   logic pin_n_q_r;
   // register state
   logic [6:0] cause_r;
   logic cmp_en_r;
   logic mcd_en_r;
   logic vdd_en_r;
   logic [3:0] hold_r;
   logic [7:0] rdata_r;
   // bus decode and source arbitration
   logic hit;
   logic wr_hit;
   logic sw_force;
   logic start;
   rcl_src_e src;

   // one-hot cause pattern for a flag position; bit 7 is never a flag, so
   // only the seven flag bits are handed back
   function automatic logic [6:0] rcl_onehot(input int pos);
      logic [7:0] full;
      full = 8'h01 << pos;
      rcl_onehot = full[6:0];
   endfunction

   // a level counts only once stages two and three agree, so a glitch of a
   // single cycle caught by the first stage never reaches the cause logic
   function automatic logic rcl_settled(input logic [2:0] s, input logic q);
      rcl_settled = q;
      if (s[1] == s[2]) begin
         rcl_settled = s[2];
      end
   endfunction

   // three-stage synchronisers; a level is accepted once stages two and three agree
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mem_s_r <= RCL_SYNC_LOW;
         cmp_s_r <= RCL_SYNC_HIGH;
         wdt_s_r <= RCL_SYNC_LOW;
         mcd_s_r <= RCL_SYNC_LOW;
         vdd_s_r <= RCL_SYNC_LOW;
         pin_s_r <= RCL_SYNC_HIGH;
      end else begin
         mem_s_r <= {mem_s_r[1:0], MEM_ERR_I};
         cmp_s_r <= {cmp_s_r[1:0], CMP_OUT_I};
         wdt_s_r <= {wdt_s_r[1:0], WDT_OVF_I};
         mcd_s_r <= {mcd_s_r[1:0], MCD_TIMEOUT_I};
         vdd_s_r <= {vdd_s_r[1:0], VDD_LOW_I};
         pin_s_r <= {pin_s_r[1:0], PIN_RST_N_I};
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mem_q_r <= 1'b0;
         cmp_q_r <= 1'b1;
         wdt_q_r <= 1'b0;
         mcd_q_r <= 1'b0;
         vdd_q_r <= 1'b0;
         pin_n_q_r <= 1'b1;
      end else begin
         mem_q_r <= rcl_settled(mem_s_r, mem_q_r);
         cmp_q_r <= rcl_settled(cmp_s_r, cmp_q_r);
         wdt_q_r <= rcl_settled(wdt_s_r, wdt_q_r);
         mcd_q_r <= rcl_settled(mcd_s_r, mcd_q_r);
         vdd_q_r <= rcl_settled(vdd_s_r, vdd_q_r);
         pin_n_q_r <= rcl_settled(pin_s_r, pin_n_q_r);
      end
   end

   assign hit = (SFR_ADDR_I == RCL_ADDR_RESET_CAUSE);
   assign wr_hit = SFR_WR_I && hit;
   // the force is taken combinationally so the reset starts at the very edge
   // that takes the write, before the processor can fetch another instruction
   assign sw_force = wr_hit && SFR_WDATA_I[RCL_BIT_SW];
   // a new event is accepted only while no reset request is running
   assign start = (src != RCL_SRC_NONE) && (hold_r == RCL_HOLD_ZERO);

   // source priority: supply first, then pin, then the internal sources
   // a sagging supply makes every other flag untrustworthy, so it wins; the pin
   // comes next as it is the one source driven straight from outside
   always_comb begin
      src = RCL_SRC_NONE;
      if (vdd_en_r && vdd_q_r) src = RCL_SRC_VDD;
      else if (!pin_n_q_r) src = RCL_SRC_PIN;
      else if (mem_q_r) src = RCL_SRC_MEM;
      else if (cmp_en_r && !cmp_q_r) src = RCL_SRC_CMP;
      else if (sw_force) src = RCL_SRC_SW;
      else if (wdt_q_r) src = RCL_SRC_WDT;
      else if (mcd_en_r && mcd_q_r) src = RCL_SRC_MCD;
   end

   // cause flags; a new reset replaces the whole record with one flag
   // the power-on value is the supply flag alone, every other flag clear
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cause_r <= RCL_CAUSE_POR[6:0];
      end else if (hold_r == RCL_HOLD_ZERO) begin
         case (src)
            RCL_SRC_MEM: cause_r <= rcl_onehot(RCL_BIT_MEM);
            RCL_SRC_CMP: cause_r <= rcl_onehot(RCL_BIT_CMP);
            RCL_SRC_SW: cause_r <= rcl_onehot(RCL_BIT_SW);
            RCL_SRC_WDT: cause_r <= rcl_onehot(RCL_BIT_WDT);
            RCL_SRC_MCD: cause_r <= rcl_onehot(RCL_BIT_MCD);
            RCL_SRC_VDD: cause_r <= rcl_onehot(RCL_BIT_POR);
            RCL_SRC_PIN: cause_r <= rcl_onehot(RCL_BIT_PIN);
            default: cause_r <= cause_r;
         endcase
      end
   end

   // enables are write-only; a system reset returns them to off, as the chip restarts
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmp_en_r <= 1'b0;
         mcd_en_r <= 1'b0;
         vdd_en_r <= 1'b0;
      end else if (start) begin
         cmp_en_r <= 1'b0;
         mcd_en_r <= 1'b0;
         vdd_en_r <= 1'b0;
      end else if (wr_hit) begin
         // writing 0 leaves an enable alone, hence no read-modify-write is needed
         if (SFR_WDATA_I[RCL_BIT_CMP]) begin
            cmp_en_r <= 1'b1;
         end
         if (SFR_WDATA_I[RCL_BIT_MCD]) begin
            mcd_en_r <= 1'b1;
         end
         if (SFR_WDATA_I[RCL_BIT_POR]) begin
            vdd_en_r <= 1'b1;
         end
      end
   end

   // reset request stretch so every block sees a clean pulse
   // limitation: a source that rises while the request runs is dropped, not
   // queued; one still standing afterwards starts a fresh request
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         hold_r <= RCL_HOLD_ZERO;
      end else if (hold_r != RCL_HOLD_ZERO) begin
         hold_r <= hold_r - RCL_HOLD_STEP;
      end else if (start) begin
         hold_r <= RCL_HOLD_CYCLES;
      end
   end

   // read data registered one cycle after the strobe
   // a read of another address leaves the last answer standing
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_r <= RCL_ZERO;
      end else if (SFR_RD_I && hit) begin
         rdata_r <= {1'b0, cause_r} & RCL_READ_MASK;
      end
   end

   // the select is a combinational handshake and the reset request a decode of hold_r, everything else comes from flops
   assign SFR_RDATA_O = rdata_r;
   assign SFR_SEL_O = hit;
   assign CMP_RESET_EN_O = cmp_en_r;
   assign MCD_EN_O = mcd_en_r;
   assign VDD_RESET_EN_O = vdd_en_r;
   assign SYS_RESET_O = (hold_r != RCL_HOLD_ZERO);
endmodule
